// file: hdl/tsio_card.v
// test serial io card: two transmit channels, one receive channel
// assumes host strobes are one-cycle pulses synchronous to clk
//
// Function
// - two independent transmit channels and one receive channel on differential lines
// - receive bits are taken on the remote unit's own clock edges
// - first received bit of a word is the most significant bit
// - test/normal selector after line buffer; normal routes line into receive RAM
// - receive RAM holds 4096 bits before host must service it
// - stored data raises an interrupt; acknowledge puts vector on bus
// - service reads bits from RAM through access shifter into parallel words
// - host word loads the access shifter and is made serial
// - serial bits go into transmit RAM under host commands
// - transmit RAM has two sections of 2047 bits, one per channel
// - each channel has its own control logic building its stream
// - both channels send each word most significant bit first
// - channel A runs at 125 kHz, channel B at 1 MHz
`timescale 1ns/10ps
`default_nettype none
`include "tsio_regs.vh"

module tsio_card (
	// clock and reset
	input  wire        clk,
	input  wire        rst,
	// host transmit command port
	input  wire        txWrite,
	input  wire        txChan,
	input  wire [15:0] txData,
	output wire        txReady,
	// host receive control
	input  wire        rxEnable,
	input  wire        testMode,
	input  wire [7:0]  rxLevel,
	input  wire        rdReq,
	output reg  [15:0] rdData_q,
	output reg         rdValid_q,
	output reg  [12:0] rxCount_q,
	output reg         rxOverflow_q,
	// interrupt handshake
	output reg         intReq_q,
	input  wire        intAck,
	output reg  [7:0]  vecOut_q,
	output reg         vecValid_q,
	// receive line from the unit under test
	input  wire        rxDataP,
	input  wire        rxDataN,
	input  wire        rxClkP,
	input  wire        rxClkN,
	// transmit lines to the unit under test
	output wire        txAP,
	output wire        txAN,
	output wire        txBP,
	output wire        txBN,
	output reg  [1:0]  txBusy_q
);

	// ============================================================
	// host word buffer in front of the access shifter
	wire        fifoValid;
	wire [16:0] fifoData;
	reg         fifoPop;

	tsio_fifo #(
		.WIDTH (17),
		.DEPTH (`TSIO_FIFO_DEPTH),
		.AW    (4)
	) tsio_fifo_i (
		.clk      (clk),
		.rst      (rst),
		.inValid  (txWrite),
		.inData   ({txChan, txData}),
		.inReady  (txReady),
		.outValid (fifoValid),
		.outData  (fifoData),
		.outReady (fifoPop)
	);

	// ============================================================
	// access controller state
	reg [2:0]  state_q;
	reg [15:0] shift_q;
	reg [3:0]  bitCnt_q;
	reg        chan_q;
	wire [1:0] txFree;
	wire [1:0] sendNow;
	wire [1:0] sendBit;
	wire       txWrBit;
	wire [1:0] txWrEn;
	wire       rxRdEn;
	wire [1:0] lineP;
	wire [1:0] lineN;
	wire [1:0] txPend;

	// serial stream into transmit RAM, top bit first
	assign txWrBit   = shift_q[15];
	assign txWrEn[0] = (state_q == `TSIO_ST_TXSH) & ~chan_q;
	assign txWrEn[1] = (state_q == `TSIO_ST_TXSH) & chan_q;
	assign rxRdEn    = (state_q == `TSIO_ST_RXSH);

	// ============================================================
	// transmit channels; one RAM section and rate divider each
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1)
		begin : gTx
			localparam integer DIVI = (ch == 0) ? `TSIO_TXA_DIV : `TSIO_TXB_DIV;
			// both dividers fit nine bits; the cut is deliberate
			localparam [8:0]   DIV  = DIVI[8:0];
			reg        ram [0:`TSIO_TX_RAM_BITS-1];
			reg [10:0] wrPtr_q;
			reg [10:0] rdPtr_q;
			reg [11:0] count_q;
			reg [8:0]  div_q;
			reg        lineP_q;
			reg        lineN_q;
			wire       tick;
			wire       send;
			wire       wr;

			assign tick = (div_q == DIV - 9'h001);
			assign send = tick & (count_q != 12'h000);
			assign wr   = txWrEn[ch];
			// room for one whole word before a load is allowed
			assign txFree[ch]  = (count_q <= (`TSIO_TX_RAM_BITS - `TSIO_WORD_BITS));
			assign sendNow[ch] = send;
			assign sendBit[ch] = ram[rdPtr_q];
			assign lineP[ch]   = lineP_q;
			assign lineN[ch]   = lineN_q;
			assign txPend[ch]  = (count_q != 12'h000);

			// channel control: pace, count and drive the line
			always @(posedge clk)
			begin
				if (rst)
				begin
					wrPtr_q <= 11'h000;
					rdPtr_q <= 11'h000;
					count_q <= 12'h000;
					div_q   <= 9'h000;
					lineP_q <= 1'b1;
					lineN_q <= 1'b0;
				end
				else
				begin
					div_q <= tick ? 9'h000 : div_q + 9'h001;
					if (wr)
						wrPtr_q <= (wrPtr_q == `TSIO_TX_RAM_BITS - 1) ? 11'h000
						           : wrPtr_q + 11'h001;
					if (send)
					begin
						rdPtr_q <= (rdPtr_q == `TSIO_TX_RAM_BITS - 1) ? 11'h000
						           : rdPtr_q + 11'h001;
						lineP_q <= ram[rdPtr_q];
						lineN_q <= ~ram[rdPtr_q];
					end
					else if (tick)
					begin
						lineP_q <= 1'b1;                    // idle mark when drained
						lineN_q <= 1'b0;
					end
					if (wr & ~send)
						count_q <= count_q + 12'h001;
					else if (send & ~wr)
						count_q <= count_q - 12'h001;
				end
			end

			// section storage
			always @(posedge clk)
			begin
				if (wr)
					ram[wrPtr_q] <= txWrBit;
			end
		end
	endgenerate

	assign txAP = lineP[0];
	assign txAN = lineN[0];
	assign txBP = lineP[1];
	assign txBN = lineN[1];

	// ============================================================
	// receive line buffer and test/normal selector
	reg        rxClkPrev_q;
	reg        rxRam [0:`TSIO_RX_RAM_BITS-1];
	reg [11:0] rxWrPtr_q;
	reg [11:0] rxRdPtr_q;
	wire       lineValid;
	wire       lineClk;
	wire       selEdge;
	wire       selBit;
	wire       rxFull;
	wire       rxStore;

	// a line only counts when its pair disagrees
	assign lineValid = rxDataP ^ rxDataN;
	assign lineClk   = rxClkP & ~rxClkN;
	// in normal mode the remote clock rising edge paces storage, no local rate
	assign selEdge = testMode ? sendNow[0]
	                 : (lineClk & ~rxClkPrev_q & lineValid);
	// test mode loops channel A back for self-test
	assign selBit  = testMode ? sendBit[0] : rxDataP;
	assign rxFull  = (rxCount_q == `TSIO_RX_RAM_BITS);
	assign rxStore = selEdge & rxEnable & ~rxFull;

	// receive write pointer, edge history and overflow
	always @(posedge clk)
	begin
		if (rst)
		begin
			rxClkPrev_q  <= 1'b0;
			rxWrPtr_q    <= 12'h000;
			rxOverflow_q <= 1'b0;
		end
		else
		begin
			rxClkPrev_q <= lineClk;
			if (rxStore)
				rxWrPtr_q <= rxWrPtr_q + 12'h001;
			// a bit lost to a full RAM is sticky until receive is disabled
			if (selEdge & rxEnable & rxFull)
				rxOverflow_q <= 1'b1;
			else if (~rxEnable)
				rxOverflow_q <= 1'b0;
		end
	end

	// receive storage; arrival order keeps the top bit first
	always @(posedge clk)
	begin
		if (rxStore)
			rxRam[rxWrPtr_q] <= selBit;
	end

	// stored bit count, written and drained in the same cycle
	always @(posedge clk)
	begin
		if (rst)
			rxCount_q <= 13'h0000;
		else if (rxStore & ~rxRdEn)
			rxCount_q <= rxCount_q + 13'h0001;
		else if (rxRdEn & ~rxStore)
			rxCount_q <= rxCount_q - 13'h0001;
	end

	// ============================================================
	// access controller: read service wins over transmit loads
	always @*
	begin
		fifoPop = 1'b0;
		if ((state_q == `TSIO_ST_IDLE) & ~(rdReq & (rxCount_q >= 13'h0010)))
			fifoPop = fifoValid & txFree[fifoData[16]];
	end

	always @(posedge clk)
	begin
		if (rst)
		begin
			state_q   <= `TSIO_ST_IDLE;
			shift_q   <= 16'h0000;
			bitCnt_q  <= 4'h0;
			chan_q    <= 1'b0;
			rxRdPtr_q <= 12'h000;
			rdData_q  <= 16'h0000;
			rdValid_q <= 1'b0;
			txBusy_q  <= 2'h0;
		end
		else
		begin
			rdValid_q <= 1'b0;
			txBusy_q  <= txPend;
			case (state_q)
				`TSIO_ST_IDLE:
				begin
					bitCnt_q <= 4'h0;
					// a read with less than a word stored is ignored
					if (rdReq & (rxCount_q >= 13'h0010))
						state_q <= `TSIO_ST_RXSH;
					else if (fifoPop)
					begin
						shift_q <= fifoData[15:0];
						chan_q  <= fifoData[16];
						state_q <= `TSIO_ST_TXSH;
					end
				end
				`TSIO_ST_TXSH:
				begin
					shift_q  <= {shift_q[14:0], 1'b0};
					bitCnt_q <= bitCnt_q + 4'h1;
					if (bitCnt_q == 4'hf)
						state_q <= `TSIO_ST_IDLE;
				end
				`TSIO_ST_RXSH:
				begin
					// first stored bit ends up in bit 15
					shift_q   <= {shift_q[14:0], rxRam[rxRdPtr_q]};
					rxRdPtr_q <= rxRdPtr_q + 12'h001;
					bitCnt_q  <= bitCnt_q + 4'h1;
					if (bitCnt_q == 4'hf)
					begin
						rdData_q  <= {shift_q[14:0], rxRam[rxRdPtr_q]};
						rdValid_q <= 1'b1;
						state_q   <= `TSIO_ST_IDLE;
					end
				end
				default:
					state_q <= `TSIO_ST_IDLE;
			endcase
		end
	end

	// ============================================================
	// interrupt: raise at level, hold until acknowledge, re-arm below level
	reg        served_q;
	wire       atLevel;
	wire [12:0] levelBits;

	// level zero still waits for a whole word
	assign levelBits = (rxLevel == 8'h00) ? 13'h0010 : {1'b0, rxLevel, 4'h0};
	assign atLevel   = (rxCount_q >= levelBits);

	always @(posedge clk)
	begin
		if (rst)
		begin
			intReq_q   <= 1'b0;
			served_q   <= 1'b0;
			vecOut_q   <= 8'h00;
			vecValid_q <= 1'b0;
		end
		else
		begin
			vecValid_q <= 1'b0;
			if (intReq_q & intAck)
			begin
				// vector presented one cycle; host scales it by four
				vecOut_q   <= `TSIO_VECTOR;
				vecValid_q <= 1'b1;
				intReq_q   <= 1'b0;
				served_q   <= 1'b1;
			end
			else if (atLevel & rxEnable & ~served_q)
				intReq_q <= 1'b1;
			if (~intReq_q & served_q & ~atLevel)
				served_q <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// file: hdl/tsio_fifo.v
// first-in first-out word buffer with valid/ready on both sides
// assumes one clock, synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none

module tsio_fifo #(
	parameter WIDTH = 17,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	// clock and reset
	input  wire             clk,
	input  wire             rst,
	// fill side
	input  wire             inValid,
	input  wire [WIDTH-1:0] inData,
	output wire             inReady,
	// drain side
	output wire             outValid,
	output wire [WIDTH-1:0] outData,
	input  wire             outReady
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wrPtr_q;
	reg [AW-1:0]    rdPtr_q;
	reg [AW:0]      count_q;
	reg             notFull_q;
	reg             empty_q;
	wire            push;
	wire            pop;
	reg  [AW:0]     countD;

	// ============================================================
	// handshakes; flags are registered so ready is glitch free
	assign inReady  = notFull_q;
	assign outValid = ~empty_q;
	assign outData  = mem[rdPtr_q];
	assign push     = inValid & notFull_q;
	assign pop      = outReady & ~empty_q;

	always @*
	begin
		countD = count_q;
		if (push & ~pop)
			countD = count_q + 1'b1;
		else if (pop & ~push)
			countD = count_q - 1'b1;
	end

	// pointers, flags and storage
	always @(posedge clk)
	begin
		if (rst)
		begin
			wrPtr_q <= {AW{1'b0}};
			rdPtr_q <= {AW{1'b0}};
			count_q <= {(AW+1){1'b0}};
			notFull_q <= 1'b1;
			empty_q <= 1'b1;
		end
		else
		begin
			if (push)
				wrPtr_q <= wrPtr_q + 1'b1;
			if (pop)
				rdPtr_q <= rdPtr_q + 1'b1;
			count_q <= countD;
			notFull_q <= (countD != DEPTH[AW:0]);
			empty_q <= (countD == {(AW+1){1'b0}});
		end
	end

	// storage needs no reset
	always @(posedge clk)
	begin
		if (push)
			mem[wrPtr_q] <= inData;
	end

endmodule

`default_nettype wire

// file: hdl/tsio_regs.vh
// constants for the test serial io channel card
// assumes a 50 MHz system clock; included by tsio_card.v
`ifndef TSIO_REGS_VH
`define TSIO_REGS_VH

// ============================================================
// clock and line rates
`define TSIO_CLK_HZ        50000000
`define TSIO_TXA_RATE_HZ   125000
`define TSIO_TXB_RATE_HZ   998400
`define TSIO_TXA_DIV       (`TSIO_CLK_HZ / `TSIO_TXA_RATE_HZ)
`define TSIO_TXB_DIV       (`TSIO_CLK_HZ / `TSIO_TXB_RATE_HZ)

// ============================================================
// storage sizes
`define TSIO_WORD_BITS     16
`define TSIO_RX_RAM_BITS   4096
`define TSIO_TX_RAM_BITS   2047
`define TSIO_FIFO_DEPTH    16

// ============================================================
// interrupt vector, arbitrary value
`define TSIO_VECTOR        8'h5a

// ============================================================
// access controller states, one-hot
`define TSIO_ST_IDLE       3'h1
`define TSIO_ST_TXSH       3'h2
`define TSIO_ST_RXSH       3'h4

`endif

// file: test/test_serial_io_channels_tb_top.sv
// self-checking bench for tsio_card against the remote unit model
// assumes the checker binds itself in from its own file
`timescale 1ns/10ps
`default_nettype none

// ========================================
// bench top
module test_serial_io_channels_tb_top;
	// host side drives
	logic        clk      = 1'b0;
	logic        rst      = 1'b1;
	logic        txWrite  = 1'b0;
	logic        txChan   = 1'b0;
	logic [15:0] txData   = 16'h0;
	logic        rxEnable = 1'b0;
	logic        testMode = 1'b0;
	logic [7:0]  rxLevel  = 8'h0;
	logic        rdReq    = 1'b0;
	logic        intAck   = 1'b0;
	int          nErrors  = 0;
	int          nTests   = 0;
	// design outputs and lines
	wire         txReady, rdValid_q, rxOverflow_q, intReq_q, vecValid_q;
	wire         rxDataP, rxDataN, rxClkP, rxClkN, txAP, txAN, txBP, txBN;
	wire  [15:0] rdData_q;
	wire  [12:0] rxCount_q;
	wire  [7:0]  vecOut_q;
	wire  [1:0]  txBusy_q;
	wire  [31:0] gotA, gotB;

	always #10 clk = ~clk;

	tsio_card tsio_card_i (.clk, .rst, .txWrite, .txChan, .txData, .txReady, .rxEnable,
		.testMode, .rxLevel, .rdReq, .rdData_q, .rdValid_q, .rxCount_q, .rxOverflow_q,
		.intReq_q, .intAck, .vecOut_q, .vecValid_q, .rxDataP, .rxDataN, .rxClkP,
		.rxClkN, .txAP, .txAN, .txBP, .txBN, .txBusy_q);
	tsio_uut_model tsio_uut_model_i (.clk, .txAP, .txBP, .rxDataP, .rxDataN, .rxClkP,
		.rxClkN, .gotA, .gotB);

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
		nTests++;
		if (seen !== want)
		begin
			nErrors++;
			$display("wrong value %s: expected %h, seen %h", what, want, seen);
		end
	endtask

	task automatic wrapUp;
		if (nErrors == 0 && nTests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// one host word, issued only while there is room
	task automatic put(input logic ch, input logic [15:0] d);
		@(negedge clk);
		for (int k = 0; k < 3000 && txReady !== 1'b1; k++) @(negedge clk);
		@(posedge clk);
		txWrite <= 1'b1;
		txChan  <= ch;
		txData  <= d;
		@(posedge clk);
		txWrite <= 1'b0;
	endtask

	task automatic tReset;
		@(posedge clk);
		rst <= 1'b1;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		check("reset", {txReady, txAP, txAN, txBP, txBN, intReq_q, rxCount_q}, 19'h68000);
	endtask

	// interleaved words must land each on its own line, top bit first
	task automatic tTx;
		put(1'b0, 16'h5a3c);
		put(1'b1, 16'h3c96);
		put(1'b0, 16'h0ff1);
		repeat (40) @(posedge clk);
		for (int k = 0; k < 20000 && txBusy_q !== 2'h0; k++) @(negedge clk);
		repeat (400) @(posedge clk);
		check("line a", gotA, 32'h5a3c0ff1);
		check("line b", gotB, 32'h3c96ffff);
	endtask

	// acknowledge gives the vector, then one read returns the oldest word
	task automatic ackRead(input logic [15:0] w, input logic [12:0] left);
		@(posedge clk);
		intAck <= 1'b1;
		@(posedge clk);
		intAck <= 1'b0;
		@(negedge clk);
		check("vector", {vecValid_q, intReq_q, vecOut_q}, 10'h25a);
		check("vector address", {vecOut_q, 2'b00}, 32'h168);
		@(posedge clk);
		rdReq <= 1'b1;
		@(posedge clk);
		rdReq <= 1'b0;
		repeat (16) @(posedge clk);
		@(negedge clk);
		check("read", {rdValid_q, rdData_q, rxCount_q}, {1'b1, w, left});
	endtask

	// bits before enable are dropped; one word then raises the request
	task automatic tRx;
		tsio_uut_model_i.send(16'hffff, 1, 1);
		@(negedge clk);
		check("count off", rxCount_q, 13'h0);
		@(posedge clk);
		rxLevel  <= 8'h1;
		rxEnable <= 1'b1;
		tsio_uut_model_i.send(16'ha5c3, 1, 3);
		repeat (2) @(posedge clk);
		@(negedge clk);
		check("count", {intReq_q, rxCount_q}, 14'h2010);
		ackRead(16'ha5c3, 13'h0);
	endtask

	// loopback through channel A stores each bit as the line sends it
	task automatic tLoop;
		@(posedge clk);
		testMode <= 1'b1;
		put(1'b0, 16'h3c5a);
		for (int k = 0; k < 8000 && intReq_q !== 1'b1; k++) @(negedge clk);
		check("loop count", rxCount_q, 13'h10);
		ackRead(16'h3c5a, 13'h0);
		@(posedge clk);
		testMode <= 1'b0;
	endtask

	// a full store loses later bits and flags it until disabled
	task automatic tOverflow;
		tsio_uut_model_i.send(16'h6b2d, 257, 1);
		@(negedge clk);
		check("full", {rxOverflow_q, rxCount_q}, 14'h3000);
		ackRead(16'h6b2d, 13'hff0);
		@(posedge clk);
		rxEnable <= 1'b0;
		repeat (2) @(negedge clk);
		check("flag off", rxOverflow_q, 1'b0);
	endtask

	// words are posted until the buffer refuses, then room must return
	task automatic tFill;
		int k;
		k = 0;
		while (k < 200 && txReady === 1'b1)
		begin
			put(1'b1, 16'h4000 + 16'(k));
			@(negedge clk);
			k++;
		end
		check("refused", txReady, 1'b0);
		repeat (20) @(negedge clk);
		check("room", txReady, 1'b1);
	endtask

	initial
	begin
		tReset;
		tTx;
		tRx;
		tLoop;
		tOverflow;
		tFill;
		tReset;
		wrapUp;
	end

	// tests need about 28k cycles; nearly three times that is a hang
	initial
	begin
		repeat (80000) @(posedge clk);
		nErrors++;
		wrapUp;
	end
endmodule

`default_nettype wire

// file: test/tsio_card_assertions.sv
// port checker for tsio_card, bound in at the foot of this file
// assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none

// ========================================
// checker
module tsio_card_checker (
	// clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// receive side
	input wire logic        rxEnable,
	input wire logic        testMode,
	input wire logic        rxDataP,
	input wire logic        rxDataN,
	input wire logic        rxClkP,
	input wire logic        rxClkN,
	input wire logic [12:0] rxCount_q,
	input wire logic        rxOverflow_q,
	input wire logic        rdValid_q,
	// interrupt
	input wire logic        intReq_q,
	input wire logic        intAck,
	input wire logic [7:0]  vecOut_q,
	input wire logic        vecValid_q,
	// transmit lines
	input wire logic        txAP,
	input wire logic        txAN,
	input wire logic        txBP,
	input wire logic        txBN,
	input wire logic [1:0]  txBusy_q
);
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (rst);

	logic [15:0] gapA_q;
	logic [15:0] gapB_q;
	logic        lastA_q;
	logic        lastB_q;
	logic        seenA_q;
	logic        seenB_q;
	wire         edgeA = txAP != lastA_q;
	wire         edgeB = txBP != lastB_q;

	// cycles since each line moved; only judged inside a burst,
	// since the divider phase is free when a section starts
	always @(posedge clk)
	begin
		gapA_q  <= (rst || edgeA) ? 16'h0 : gapA_q + 16'h1;
		gapB_q  <= (rst || edgeB) ? 16'h0 : gapB_q + 16'h1;
		seenA_q <= !rst && txBusy_q[0] && (seenA_q || edgeA);
		seenB_q <= !rst && txBusy_q[1] && (seenB_q || edgeB);
		lastA_q <= txAP;
		lastB_q <= txBP;
	end

	vec_on_ack_a: assert property (intReq_q && intAck |=> vecValid_q && !intReq_q
		&& vecOut_q == 8'h5a) else $error("no vector after acknowledge");
	irq_holds_a: assert property (intReq_q && !intAck |=> intReq_q)
		else $error("request dropped unacknowledged");
	vec_needs_ack_a: assert property (vecValid_q |-> $past(intReq_q && intAck))
		else $error("vector without acknowledge");
	read_pulse_a: assert property (rdValid_q |=> !rdValid_q)
		else $error("read valid too long");
	lines_diff_a: assert property (txAN == !txAP && txBN == !txBP)
		else $error("line pair not complementary");
	rate_a_a: assert property (seenA_q && edgeA |-> gapA_q % 400 == 399)
		else $error("line a off its bit rate");
	rate_b_a: assert property (seenB_q && edgeB |-> gapB_q % 50 == 49)
		else $error("line b off its bit rate");
	full_flag_a: assert property (rxCount_q == 13'h1000 && rxEnable && !testMode
		&& rxDataP != rxDataN && $rose(rxClkP && !rxClkN) |=> rxOverflow_q)
		else $error("lost bit not flagged");
	no_store_off_a: assert property (!rxEnable |=> rxCount_q <= $past(rxCount_q))
		else $error("bit stored while disabled");
endmodule

bind tsio_card tsio_card_checker tsio_card_checker_i (.clk, .rst, .rxEnable, .testMode,
	.rxDataP, .rxDataN, .rxClkP, .rxClkN, .rxCount_q, .rxOverflow_q, .rdValid_q,
	.intReq_q, .intAck, .vecOut_q, .vecValid_q, .txAP, .txAN, .txBP, .txBN, .txBusy_q);

`default_nettype wire

// file: test/tsio_uut_model.sv
// model of the unit under test: remote sender and two line listeners
// assumes bursts on the transmit lines begin with a zero bit
`timescale 1ns/10ps
`default_nettype none

// ========================================
// line listener
module tsio_uut_listen #(
	parameter int DIV = 400
) (
	// clock and line
	input  wire logic        clk,
	input  wire logic        lineP,
	// bits heard, first in the top bit
	output var  logic [31:0] word
);
	// no framing on the line, so a burst is found by its leading zero
	initial
	begin
		word = 32'h0;
		forever
		begin
			@(negedge lineP);
			repeat (DIV / 2) @(posedge clk);
			for (int i = 0; i < 32; i++)
			begin
				word = {word[30:0], lineP};
				repeat (DIV) @(posedge clk);
			end
		end
	end
endmodule

// ========================================
// remote unit
module tsio_uut_model (
	// card clock and lines from the card
	input  wire logic        clk,
	input  wire logic        txAP,
	input  wire logic        txBP,
	// receive pairs into the card
	output var  logic        rxDataP,
	output var  logic        rxDataN,
	output var  logic        rxClkP,
	output var  logic        rxClkN,
	// words heard on each line
	output wire logic [31:0] gotA,
	output wire logic [31:0] gotB
);
	// remote clock at rest low between frames
	initial
	begin
		rxClkP  = 1'b0;
		rxClkN  = 1'b1;
		rxDataP = 1'b0;
		rxDataN = 1'b1;
	end

	tsio_uut_listen #(.DIV(400)) tsio_uut_listen_i (.clk, .lineP(txAP), .word(gotA));
	tsio_uut_listen #(.DIV(50)) tsio_uut_listen_b_i (.clk, .lineP(txBP), .word(gotB));

	// n whole words, top bit first; gap sets how slow the remote clock is
	task automatic send(input logic [15:0] w, input int n, input int gap);
		for (int i = 0; i < n * 16; i++)
		begin
			@(posedge clk);
			rxClkP  <= 1'b0;
			rxClkN  <= 1'b1;
			rxDataP <= w[15 - i % 16];
			rxDataN <= !w[15 - i % 16];
			repeat (gap) @(posedge clk);
			rxClkP  <= 1'b1;
			rxClkN  <= 1'b0;
		end
		// clock stops; data shows the inverse of the last bit
		@(posedge clk);
		rxClkP  <= 1'b0;
		rxClkN  <= 1'b1;
		rxDataP <= !w[0];
		rxDataN <= w[0];
	endtask
endmodule

`default_nettype wire
